/* File: inc/sfe_pkg.sv */
// sfe_pkg: constants and types of the serial flash front end.
// assumes one 40 MHz core clock; pins arrive unsynchronised.
package sfe_pkg;

  // command opcodes
  localparam logic [7:0] SFE_OPC_PROG = 8'h02;
  localparam logic [7:0] SFE_OPC_READ = 8'h03;
  localparam logic [7:0] SFE_OPC_RDSR = 8'h05;
  localparam logic [7:0] SFE_OPC_ER4K = 8'h20;
  localparam logic [7:0] SFE_OPC_ER32K = 8'h52;
  localparam logic [7:0] SFE_OPC_ER64K = 8'hd8;
  localparam logic [7:0] SFE_OPC_ERCHIP = 8'hc7;
  localparam logic [7:0] SFE_OPC_RDID = 8'h9f;
  localparam logic [7:0] SFE_OPC_PROT = 8'h36;
  localparam logic [7:0] SFE_OPC_UNPROT = 8'h39;
  localparam logic [7:0] SFE_OPC_GPROT = 8'h3c;
  localparam logic [7:0] SFE_OPC_GUNPROT = 8'h3d;

  // array geometry
  localparam int SFE_ADDR_W = 24;
  localparam int SFE_PAGE_BYTES = 256;
  localparam int SFE_SECTORS = 64;
  localparam int SFE_SECT_LSB = 16;
  localparam logic [1:0] SFE_ADDR_LAST = 2'h2;
  localparam logic [1:0] SFE_ADDR_FULL = 2'h3;
  localparam logic [8:0] SFE_PAGE_CNT = 9'h100;

  // status byte bit positions
  localparam int SFE_ST_BUSY = 0;
  localparam int SFE_ST_FAIL = 1;
  localparam int SFE_ST_WPN = 2;
  localparam int SFE_ST_ALLPROT = 3;

  // read data latency, core cycles after rd_req, and index of the last identity byte
  localparam logic [1:0] SFE_RD_LAT = 2'h2;
  localparam logic [1:0] SFE_ID_LAST = 2'h2;

  typedef enum logic [2:0] {
    SFE_PH_IDLE = 3'b000,
    SFE_PH_CMD  = 3'b001,
    SFE_PH_ADDR = 3'b010,
    SFE_PH_DATA = 3'b011,
    SFE_PH_OUT  = 3'b100,
    SFE_PH_HOLD = 3'b101,
    SFE_PH_SKIP = 3'b110
  } sfe_phase_t;

  typedef enum logic [2:0] {
    SFE_OP_PROG   = 3'b000,
    SFE_OP_ER4K   = 3'b001,
    SFE_OP_ER32K  = 3'b010,
    SFE_OP_ER64K  = 3'b011,
    SFE_OP_ERCHIP = 3'b100
  } sfe_op_kind_t;

  typedef struct packed {
    sfe_op_kind_t kind;
    logic [SFE_ADDR_W-1:0] addr;
    logic [8:0] count;
  } sfe_op_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
  } sfe_pins_t;

  typedef struct packed {
    sfe_pins_t s1;
    sfe_pins_t s2;
    logic sck_prev;
    logic cs_prev;
    sfe_phase_t phase;
    logic [2:0] bcnt;
    logic [7:0] sh;
    logic [7:0] opc;
    logic [SFE_ADDR_W-1:0] addr;
    logic [1:0] acnt;
    logic [1:0] idx;
    logic [1:0] ld;
    logic [7:0] obyte;
    logic so;
    logic so_oe;
    logic [SFE_SECTORS-1:0] prot;
    logic fail;
    logic standby;
    logic op_start;
    sfe_op_t op;
    logic rd_req;
    logic [SFE_ADDR_W-1:0] rd_addr;
    logic [8:0] wcnt;
    logic bw;
    logic [7:0] bwa;
    logic [7:0] bwd;
  } sfe_st_t;

  // undriven write protect reads high, like the pad pull-up
  localparam sfe_pins_t SFE_PINS_RST = '{cs_n: 1'b1, sck: 1'b0,
                                         si: 1'b0, wp_n: 1'b1};
  localparam sfe_op_t SFE_OP_RST = '{kind: SFE_OP_PROG,
                                     addr: 24'h000000, count: 9'h000};
  // all sectors come up protected
  localparam sfe_st_t SFE_ST_RST = '{s1: SFE_PINS_RST, s2: SFE_PINS_RST,
                                     cs_prev: 1'b1, phase: SFE_PH_IDLE,
                                     prot: {SFE_SECTORS{1'b1}},
                                     standby: 1'b1, op: SFE_OP_RST,
                                     default: '0};

endpackage : sfe_pkg

/* File: verilog/sfe_page_buf.sv */
// sfe_page_buf: page buffer for program data, registered read.
// assumes one write port driven by the front end, read by the array.
`timescale 1ns/1ps
module sfe_page_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata_q
);

  logic [WIDTH-1:0] mem [DEPTH];

  // address wrap within the page relies on a power of two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
    $error("sfe_page_buf: DEPTH must be a power of two");
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end

endmodule : sfe_page_buf

/* File: verilog/sfe_spi_front.sv */
// sfe_spi_front: spi slave front end of a serial flash device.
// assumes an array engine on clk that runs program and erase jobs,
// answers reads two cycles after rd_req and reads the page buffer.
// Behaviour
// - select falling edge starts new command
// - select rising edge ends current command
// - serial output released while deselected
// - deselect gives standby, never deep power-down
// - serial input ignored while deselected
// - busy array keeps device out of standby
// - input bits sampled on clock rising edge
// - output changes only on clock falling edge
// - works with clock modes 0 and 3
// - write protect low locks protected sectors
// - undriven write protect counts as high
// - program one to 256 bytes per page
// - erase 4K, 32K, 64K blocks and chip
// - sixty-four 64K sectors for protection
// - protected sector refuses program and erase
// - global protect and unprotect of all sectors
// - failures stick in a readable status bit
// - identity bytes returned on identify command
`timescale 1ns/1ps
module sfe_spi_front
  import sfe_pkg::*;
#(
  parameter logic [7:0] MFR_ID = 8'h5a,  // arbitrary value
  parameter logic [7:0] DEV_ID1 = 8'h11,  // arbitrary value
  parameter logic [7:0] DEV_ID2 = 8'h22  // arbitrary value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic wp_n,
  output logic so,
  output logic so_oe,
  output logic standby,
  output logic op_start,
  output sfe_op_t op,
  input wire logic [7:0] buf_raddr,
  output logic [7:0] buf_rdata,
  output logic rd_req,
  output logic [SFE_ADDR_W-1:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic arr_busy,
  input wire logic arr_fail
);

  sfe_st_t st_q;
  sfe_st_t st_d;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic [7:0] byte_in;
  logic [5:0] sect;
  logic [7:0] status;
  logic [7:0] id_byte;

  ////////////////////////////////////////////////////////////////////////
  // edges of the synchronised pins
  // edge based, idle level of sck is irrelevant
  assign sck_rise = st_q.s2.sck & ~st_q.sck_prev;
  assign sck_fall = ~st_q.s2.sck & st_q.sck_prev;
  assign cs_fall = st_q.cs_prev & ~st_q.s2.cs_n;
  assign cs_rise = ~st_q.cs_prev & st_q.s2.cs_n;
  assign byte_in = {st_q.sh[6:0], st_q.s2.si};
  // sector number from the upper address bits
  assign sect = st_q.addr[SFE_SECT_LSB +: 6];

  always_comb begin
    status = 8'h00;
    status[SFE_ST_BUSY] = arr_busy;
    status[SFE_ST_FAIL] = st_q.fail;
    status[SFE_ST_WPN] = st_q.s2.wp_n;
    status[SFE_ST_ALLPROT] = &st_q.prot;
    case (st_q.idx)
      2'h0: id_byte = MFR_ID;
      2'h1: id_byte = DEV_ID1;
      2'h2: id_byte = DEV_ID2;
      default: id_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_d = st_q;
    st_d.op_start = 1'b0;
    st_d.rd_req = 1'b0;
    st_d.bw = 1'b0;
    st_d.s1 = '{cs_n: cs_n, sck: sck, si: si, wp_n: wp_n};
    st_d.s2 = st_q.s1;
    st_d.sck_prev = st_q.s2.sck;
    st_d.cs_prev = st_q.s2.cs_n;
    // standby only when deselected and the array is idle
    // the closing edge may commit a job, so it never counts as idle
    st_d.standby = st_q.s2.cs_n & ~cs_rise & ~arr_busy & ~st_q.op_start;
    if (st_q.ld == 2'h1) begin
      st_d.obyte = rd_data;
    end
    if (st_q.ld != 2'h0) begin
      st_d.ld = st_q.ld - 2'h1;
    end
    if (cs_fall) begin
      st_d.phase = SFE_PH_CMD;
      st_d.bcnt = 3'h0;
      st_d.acnt = 2'h0;
      st_d.wcnt = 9'h000;
      st_d.idx = 2'h0;
    end else if (cs_rise && st_q.bcnt == 3'h0) begin
      // commit on the closing edge, only on a byte boundary
      case (st_q.phase)
        SFE_PH_DATA: begin
          // program needs an open sector and data
          if (st_q.wcnt != 9'h000 && !st_q.prot[sect] && !arr_busy) begin
            st_d.op_start = 1'b1;
            st_d.op = '{kind: SFE_OP_PROG, addr: st_q.addr,
                        count: st_q.wcnt};
            st_d.fail = 1'b0;
          end
        end
        SFE_PH_HOLD: begin
          case (st_q.opc)
            SFE_OPC_ER4K, SFE_OPC_ER32K, SFE_OPC_ER64K: begin
              // block erase in an open sector
              if (st_q.acnt == SFE_ADDR_FULL && !st_q.prot[sect]) begin
                st_d.op_start = 1'b1;
                st_d.fail = 1'b0;
                st_d.op.addr = st_q.addr;
                st_d.op.count = 9'h000;
                st_d.op.kind = (st_q.opc == SFE_OPC_ER4K) ? SFE_OP_ER4K :
                  (st_q.opc == SFE_OPC_ER32K) ? SFE_OP_ER32K : SFE_OP_ER64K;
              end
            end
            SFE_OPC_ERCHIP: begin
              // chip erase only with nothing protected
              if (st_q.prot == '0) begin
                st_d.op_start = 1'b1;
                st_d.fail = 1'b0;
                st_d.op = '{kind: SFE_OP_ERCHIP, addr: 24'h000000,
                            count: 9'h000};
              end
            end
            SFE_OPC_PROT: begin
              if (st_q.acnt == SFE_ADDR_FULL) begin
                st_d.prot[sect] = 1'b1;
              end
            end
            SFE_OPC_UNPROT: begin
              // locked while write protect is low
              if (st_q.acnt == SFE_ADDR_FULL && st_q.s2.wp_n) begin
                st_d.prot[sect] = 1'b0;
              end
            end
            SFE_OPC_GPROT: begin
              st_d.prot = {SFE_SECTORS{1'b1}};
            end
            SFE_OPC_GUNPROT: begin
              // global unprotect also honours the lock
              if (st_q.s2.wp_n) begin
                st_d.prot = '0;
              end
            end
            default: begin
            end
          endcase
        end
        default: begin
        end
      endcase
    end else if (!st_q.s2.cs_n && sck_rise) begin
      st_d.sh = byte_in;
      st_d.bcnt = st_q.bcnt + 3'h1;
      if (st_q.bcnt == 3'h7) begin
        case (st_q.phase)
          SFE_PH_CMD: begin
            st_d.opc = byte_in;
            if (arr_busy && byte_in != SFE_OPC_RDSR) begin
              // array busy, only status may be read
              st_d.phase = SFE_PH_SKIP;
            end else begin
              case (byte_in)
                SFE_OPC_READ, SFE_OPC_PROG, SFE_OPC_ER4K,
                SFE_OPC_ER32K, SFE_OPC_ER64K, SFE_OPC_PROT,
                SFE_OPC_UNPROT: begin
                  st_d.phase = SFE_PH_ADDR;
                end
                SFE_OPC_RDSR: begin
                  st_d.phase = SFE_PH_OUT;
                  st_d.obyte = status;
                end
                SFE_OPC_RDID: begin
                  st_d.phase = SFE_PH_OUT;
                  st_d.obyte = id_byte;
                  st_d.idx = st_q.idx + 2'h1;
                end
                SFE_OPC_ERCHIP, SFE_OPC_GPROT, SFE_OPC_GUNPROT: begin
                  st_d.phase = SFE_PH_HOLD;
                end
                default: begin
                  st_d.phase = SFE_PH_SKIP;
                end
              endcase
            end
          end
          SFE_PH_ADDR: begin
            st_d.addr = {st_q.addr[15:0], byte_in};
            st_d.acnt = st_q.acnt + 2'h1;
            if (st_q.acnt == SFE_ADDR_LAST) begin
              if (st_q.opc == SFE_OPC_READ) begin
                st_d.phase = SFE_PH_OUT;
                st_d.rd_req = 1'b1;
                st_d.rd_addr = {st_q.addr[15:0], byte_in};
                st_d.ld = SFE_RD_LAT;
              end else if (st_q.opc == SFE_OPC_PROG) begin
                st_d.phase = SFE_PH_DATA;
              end else begin
                st_d.phase = SFE_PH_HOLD;
              end
            end
          end
          SFE_PH_DATA: begin
            // bytes past a full page are dropped
            if (st_q.wcnt != SFE_PAGE_CNT) begin
              st_d.bw = 1'b1;
              st_d.bwa = st_q.addr[7:0] + st_q.wcnt[7:0];
              st_d.bwd = byte_in;
              st_d.wcnt = st_q.wcnt + 9'h001;
            end
          end
          SFE_PH_OUT: begin
            if (st_q.opc == SFE_OPC_READ) begin
              st_d.rd_req = 1'b1;
              st_d.rd_addr = st_q.rd_addr + 24'h000001;
              st_d.ld = SFE_RD_LAT;
            end else if (st_q.opc == SFE_OPC_RDSR) begin
              st_d.obyte = status;
            end else begin
              st_d.obyte = id_byte;
              if (st_q.idx <= SFE_ID_LAST) begin
                st_d.idx = st_q.idx + 2'h1;
              end
            end
          end
          SFE_PH_HOLD: begin
            // extra bytes abandon the pending command
            st_d.phase = SFE_PH_SKIP;
          end
          default: begin
          end
        endcase
      end
    end else if (!st_q.s2.cs_n && sck_fall && st_q.phase == SFE_PH_OUT) begin
      // drive the next bit on the falling edge
      st_d.so_oe = 1'b1;
      st_d.so = st_q.obyte[~st_q.bcnt];
    end
    if (st_q.s2.cs_n) begin
      st_d.phase = SFE_PH_IDLE;
      st_d.so_oe = 1'b0;
    end
    // failure set wins over the clear at job start
    if (arr_fail) begin
      st_d.fail = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= SFE_ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  sfe_page_buf #(
    .WIDTH(8),
    .DEPTH(SFE_PAGE_BYTES)
  ) sfe_page_buf_inst (
    .clk(clk),
    .we(st_q.bw),
    .waddr(st_q.bwa),
    .wdata(st_q.bwd),
    .raddr(buf_raddr),
    .rdata_q(buf_rdata)
  );

  assign so = st_q.so;
  assign so_oe = st_q.so_oe;
  assign standby = st_q.standby;
  assign op_start = st_q.op_start;
  assign op = st_q.op;
  assign rd_req = st_q.rd_req;
  assign rd_addr = st_q.rd_addr;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_start;
    cs_fall |=> st_q.phase == SFE_PH_CMD && st_q.bcnt == 3'h0;
  endproperty
  a_start: assert property (p_start) else $error("no fresh command");

  property p_end;
    cs_rise |=> st_q.phase == SFE_PH_IDLE ##1 st_q.phase == SFE_PH_IDLE;
  endproperty
  a_end: assert property (p_end) else $error("command not ended");

  property p_release;
    st_q.s2.cs_n |=> !so_oe;
  endproperty
  a_release: assert property (p_release) else $error("so driven");

  property p_busy;
    arr_busy |=> !standby;
  endproperty
  a_busy: assert property (p_busy) else $error("standby while busy");

  property p_jstby;
    op_start |-> !standby;
  endproperty
  a_jstby: assert property (p_jstby) else $error("job standby");

  property p_shift;
    !st_q.s2.cs_n && sck_rise && !cs_fall |=>
      st_q.sh == {$past(st_q.sh[6:0]), $past(st_q.s2.si)};
  endproperty
  a_shift: assert property (p_shift) else $error("bad sample");

  property p_so_fall;
    !$stable(so) |-> $past(sck_fall);
  endproperty
  a_so_fall: assert property (p_so_fall) else $error("so off edge");

  property p_lock;
    !st_q.s2.wp_n |=> (~st_q.prot & $past(st_q.prot)) == '0;
  endproperty
  a_lock: assert property (p_lock) else $error("unprotect locked");

  property p_count;
    op_start && op.kind == SFE_OP_PROG |->
      op.count != 9'h000 && op.count <= SFE_PAGE_CNT;
  endproperty
  a_count: assert property (p_count) else $error("bad length");

  property p_prot;
    op_start && op.kind != SFE_OP_ERCHIP |->
      !st_q.prot[op.addr[SFE_SECT_LSB +: 6]];
  endproperty
  a_prot: assert property (p_prot) else $error("protected job");

  property p_chip;
    op_start && op.kind == SFE_OP_ERCHIP |-> st_q.prot == '0;
  endproperty
  a_chip: assert property (p_chip) else $error("chip erase locked");

  property p_fail;
    arr_fail |=> st_q.fail [*2];
  endproperty
  a_fail: assert property (p_fail) else $error("fail lost");

  c_prog: cover property (op_start && op.kind == SFE_OP_PROG);
  c_erase: cover property (op_start && op.kind == SFE_OP_ER4K);
  c_read: cover property (rd_req ##[1:100] rd_req);
  c_id: cover property (st_q.opc == SFE_OPC_RDID && sck_fall && so_oe);

endmodule : sfe_spi_front

/* File: tb/sfe_host.sv */
// sfe_host: behavioural spi host driving the flash front end pins.
// assumes the bench clock clk; sck half period is 4 clk (100 ns).
`timescale 1ns/1ps
module sfe_host (
  input wire logic clk,
  input wire logic so,
  output logic cs_n,
  output logic sck,
  output logic si
);
  logic [7:0] rxq[$];
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // released data line toggles, so no stale bit can pass for data
  always @(negedge clk) if (cs_n) si <= ~si;
  task automatic half;
    repeat (4) @(negedge clk);
  endtask : half
  ////////////////////////////////////////////////////////////////////////
  // framed, msb first, mode 0 or 3
  task automatic run(input bit m3, input logic [7:0] tx[$], input int nrx);
    logic [7:0] b;
    logic [7:0] r;
    rxq = {};
    sck = m3;
    half();
    cs_n = 1'b0;
    half();
    for (int i = 0; i < tx.size() + nrx; i++) begin
      b = (i < tx.size()) ? tx[i] : 8'h00;
      for (int k = 7; k >= 0; k--) begin
        sck = 1'b0;
        si = b[k];
        half();
        r[k] = so;
        sck = 1'b1;
        half();
      end
      if (i >= tx.size()) rxq.push_back(r);
    end
    sck = m3;
    half();
    cs_n = 1'b1;
    half();
    half();
  endtask : run
endmodule : sfe_host

/* File: tb/sfe_spi_front_tb.sv */
// sfe_spi_front_tb: self-checking bench of the spi front end.
// assumes a behavioural array engine here; busy lasts 200 clk.
`timescale 1ns/1ps
module sfe_spi_front_tb;
  import sfe_pkg::*;
  localparam logic [7:0] ID_M = 8'h5a;  // arbitrary value
  localparam logic [7:0] ID_1 = 8'h11;  // arbitrary value
  localparam logic [7:0] ID_2 = 8'h22;  // arbitrary value
  logic clk, rst_n, wp_n, arr_busy, arr_fail, fail_req;
  logic cs_n, sck, si, so, so_oe, standby, op_start, rd_req;
  logic so_p, oe_p, sck_p;
  sfe_op_t op;
  logic [7:0] buf_raddr, buf_rdata, rd_data;
  logic [SFE_ADDR_W-1:0] rd_addr;
  int num_errors, n_checks, n_ops, bcnt, desel, since_fall, n;

  sfe_spi_front #(.MFR_ID(ID_M), .DEV_ID1(ID_1), .DEV_ID2(ID_2))
    sfe_spi_front_inst (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck),
    .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe), .standby(standby),
    .op_start(op_start), .op(op), .buf_raddr(buf_raddr),
    .buf_rdata(buf_rdata), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_data(rd_data), .arr_busy(arr_busy), .arr_fail(arr_fail));
  // released so reads inverted, so a stale bit cannot pass for data
  sfe_host sfe_host_inst (.clk(clk), .so(so_oe ? so : ~so), .cs_n(cs_n),
    .sck(sck), .si(si));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  // array engine: data on the first falling clk edge after a request, fail at end of a job
  always @(negedge clk) begin
    // data only follows a request, so a lost rd_req shows in read data
    if (rd_req) rd_data <= rd_addr[7:0] ^ 8'h3c;
    arr_fail <= 1'b0;
    if (op_start) begin
      bcnt <= 200;
      arr_busy <= 1'b1;
    end else if (bcnt > 0) begin
      bcnt <= bcnt - 1;
      if (bcnt == 1) begin
        arr_busy <= 1'b0;
        arr_fail <= fail_req;
      end
    end
  end
  always @(posedge clk) if (op_start) n_ops <= n_ops + 1;
  always @(posedge clk) begin
    desel <= cs_n ? desel + 1 : 0;
    since_fall <= (sck_p && !sck) ? 0 : since_fall + 1;
    sck_p <= sck;
    so_p <= so;
    oe_p <= so_oe;
    if (desel > 4 && so_oe !== 1'b0) chk("so_oe_desel", 0, so_oe);
    if (oe_p && so_oe && so !== so_p && (since_fall < 1 || since_fall > 4))
      chk("so_change_cycle", 3, since_fall);
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic close_out;
    if (num_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic st(input logic [7:0] e);
    sfe_host_inst.run(1'b0, {SFE_OPC_RDSR}, 2);
    chk("status_a", e, sfe_host_inst.rxq[0]);
    chk("status_b", e, sfe_host_inst.rxq[1]);
  endtask : st
  task automatic idle;
    for (int i = 0; i < 400 && arr_busy; i++) @(negedge clk);
    repeat (4) @(negedge clk);
  endtask : idle
  task automatic ops(input int e);
    chk("op_start_count", e, n_ops);
  endtask : ops
  ////////////////////////////////////////////////////////////////////////
  task automatic t_frame;
    chk("standby_rst", 1, standby);
    st(8'h0c);
    sfe_host_inst.run(1'b0, {SFE_OPC_GUNPROT, 8'h00}, 0);
    st(8'h0c);
  endtask : t_frame
  task automatic t_lock;
    n = n_ops;
    sfe_host_inst.run(1'b0, {SFE_OPC_PROG, 8'h01, 8'h00, 8'h00, 8'haa}, 0);
    ops(n);
    @(negedge clk);
    wp_n = 1'b0;
    sfe_host_inst.run(1'b0, {SFE_OPC_GUNPROT}, 0);
    st(8'h08);
    @(negedge clk);
    wp_n = 1'b1;
    sfe_host_inst.run(1'b0, {SFE_OPC_GUNPROT}, 0);
    st(8'h04);
  endtask : t_lock
  task automatic t_prog;
    fail_req = 1'b1;
    n = n_ops;
    sfe_host_inst.run(1'b1, {SFE_OPC_PROG, 8'h01, 8'h23, 8'hfe, 8'h11,
                             8'h22, 8'h33}, 0);
    ops(n + 1);
    chk("op_kind", SFE_OP_PROG, op.kind);
    chk("op_addr", 24'h0123fe, op.addr);
    chk("op_count", 9'h003, op.count);
    chk("standby_busy", 0, standby);
    st(8'h05);
    idle();
    chk("standby_idle", 1, standby);
    st(8'h06);
    fail_req = 1'b0;
    for (int i = 0; i < 3; i++) begin
      buf_raddr = 8'(8'hfe + i);
      repeat (2) @(negedge clk);
      chk("page_buf", 8'(8'h11 * (i + 1)), buf_rdata);
    end
  endtask : t_prog
  task automatic t_erase;
    logic [7:0] oc[4];
    oc = '{SFE_OPC_ER4K, SFE_OPC_ER32K, SFE_OPC_ER64K, SFE_OPC_ERCHIP};
    for (int i = 0; i < 4; i++) begin
      n = n_ops;
      if (i == 3) sfe_host_inst.run(1'b0, {oc[i]}, 0);
      else sfe_host_inst.run(1'b0, {oc[i], 8'h05, 8'h10, 8'h00}, 0);
      ops(n + 1);
      chk("erase_kind", i + 1, op.kind);
      idle();
    end
    sfe_host_inst.run(1'b0, {SFE_OPC_PROT, 8'h05, 8'h00, 8'h00}, 0);
    n = n_ops;
    sfe_host_inst.run(1'b0, {SFE_OPC_ER4K, 8'h45, 8'hf0, 8'h00}, 0);
    ops(n);
    sfe_host_inst.run(1'b0, {SFE_OPC_ER4K, 8'h06, 8'h00, 8'h00}, 0);
    ops(n + 1);
    chk("erase_addr", 24'h060000, op.addr);
    idle();
    sfe_host_inst.run(1'b0, {SFE_OPC_ERCHIP}, 0);
    ops(n + 1);
  endtask : t_erase
  task automatic t_read;
    sfe_host_inst.run(1'b1, {SFE_OPC_READ, 8'h00, 8'hab, 8'hcd}, 2);
    chk("read_a", 8'hf1, sfe_host_inst.rxq[0]);
    chk("read_b", 8'hf2, sfe_host_inst.rxq[1]);
    sfe_host_inst.run(1'b0, {SFE_OPC_RDID}, 4);
    chk("id_m", ID_M, sfe_host_inst.rxq[0]);
    chk("id_1", ID_1, sfe_host_inst.rxq[1]);
    chk("id_2", ID_2, sfe_host_inst.rxq[2]);
    chk("id_end", 8'h00, sfe_host_inst.rxq[3]);
  endtask : t_read
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    num_errors++;
    close_out();
  end
  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    arr_busy = 1'b0;
    arr_fail = 1'b0;
    fail_req = 1'b0;
    rd_data = 8'h00;
    buf_raddr = 8'h00;
    bcnt = 0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_frame();
    t_lock();
    t_prog();
    t_erase();
    t_read();
    close_out();
  end
endmodule : sfe_spi_front_tb
